// [lisa_defines.svh]
// constants of the lan interrupt status and acknowledge block
`ifndef LISA_DEFINES_SVH
`define LISA_DEFINES_SVH

// byte lanes of the shared control dword
`define LISA_STAT_BYTE  0
`define LISA_CAUSE_BYTE 1
`define LISA_ICTL_BYTE  3

// field positions in the dword
`define LISA_CAUSE_LSB 8
`define LISA_CAUSE_MSB 15
`define LISA_CES_LSB   6
`define LISA_CES_MSB   7
`define LISA_RES_LSB   2
`define LISA_RES_MSB   5
`define LISA_BLK_BIT   24
`define LISA_SREQ_BIT  25
`define LISA_GATE_LSB  26
`define LISA_GATE_MSB  31

// cause indexes inside the cause byte
`define LISA_C_CMD   7
`define LISA_C_FRAME 6
`define LISA_C_INACT 5
`define LISA_C_STALL 4
`define LISA_C_MGMT  3
`define LISA_C_SOFT  2
`define LISA_C_RSV   1
`define LISA_C_PAUSE 0

// reset values
`define LISA_CAUSE_RST 8'h00
`define LISA_GATE_RST  6'h00
`define LISA_BLK_RST   1'h0
`define LISA_CES_RST   2'h0
`define LISA_RES_RST   4'h0

// engine state codes
`define LISA_CES_IDLE  2'h0
`define LISA_RES_READY 4'h4

// cycles from an engine state change to its status field
`define LISA_STATE_LAG 1

`endif

// [lisa_pkg.sv]
// types of the lan interrupt status and acknowledge block
package lisa_pkg;

  typedef logic [7:0] lisa_cause_t;
  typedef logic [5:0] lisa_gate_t;
  typedef logic [1:0] lisa_ces_t;
  typedef logic [3:0] lisa_res_t;

  typedef enum logic {
    LISA_LINE_IDLE,
    LISA_LINE_ON
  } lisa_line_e;

  typedef struct packed {
    lisa_cause_t cause;
  } lisa_flag_s;

  typedef struct packed {
    lisa_gate_t gate;
    logic       blk;
    lisa_ces_t  ces;
    lisa_res_t  res;
    lisa_line_e line;
  } lisa_core_s;

endpackage : lisa_pkg

// [lisa_flag_bank.sv]
// sticky cause flags, set by events and cleared by writing ones
`timescale 1ns/10ps
`default_nettype none
`include "lisa_defines.svh"

module lisa_flag_bank
  import lisa_pkg::*;
(
  input  wire logic        core_clk, // system clock
  input  wire logic        rstn,     // synchronous reset, active low
  input  wire lisa_cause_t set_vec,  // one-cycle cause events
  input  wire lisa_cause_t ack_vec,  // ones written to the cause byte
  output lisa_cause_t      cause     // pending cause flags
);

  lisa_flag_s st;
  lisa_flag_s next_st;

  always_comb begin
    next_st = st;
    for (int i = 0; i < 8; i++) begin
      next_st.cause[i] = (st.cause[i] & ~ack_vec[i]) | set_vec[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st.cause <= `LISA_CAUSE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign cause = st.cause;

endmodule : lisa_flag_bank
`default_nettype wire

// [lisa_status_ack.sv]
// interrupt cause, acknowledge and engine state word of the lan controller
`timescale 1ns/10ps
`default_nettype none
`include "lisa_defines.svh"

module lisa_status_ack
  import lisa_pkg::*;
(
  input  wire logic        core_clk,        // system clock, 10 mhz
  input  wire logic        rstn,            // synchronous reset, active low
  input  wire logic        reg_wr,          // write strobe of the dword
  input  wire logic [3:0]  reg_be,          // byte enables of the write
  input  wire logic [31:0] reg_wdata,       // write data
  output logic      [31:0] reg_rdata,       // read data of the dword
  input  wire logic        cmd_done_evt,    // command with request done
  input  wire logic        tx_fail_evt,     // transmit done, bad status
  input  wire logic        tno_enable,      // failed transmit raises flag, earliest variant only
  input  wire logic        early_variant,   // earliest device variant
  input  wire logic        frame_done_evt,  // whole frame received
  input  wire logic        header_done_evt, // frame header received
  input  wire logic        header_mode,     // header descriptor mode
  input  wire logic        idle_event_mode, // flag only on entering idle
  input  wire logic [1:0]  ces_in,          // command engine state
  input  wire logic [3:0]  res_in,          // receive engine state
  input  wire logic        mgmt_done_evt,   // management cycle complete
  input  wire logic        mgmt_irq_enable, // management enable bit 29
  input  wire logic        pause_evt,       // flow control pause event
  input  wire logic        intr_pin_in,     // level seen on the pin
  output logic             intr_pin_out,    // pin drive value, always 0
  output logic             intr_pin_oe_n    // low while pin is pulled
);

  lisa_core_s  st;
  lisa_core_s  next_st;
  lisa_cause_t cause;
  lisa_cause_t set_vec;
  lisa_cause_t ack_vec;
  lisa_cause_t gate_vec;
  logic        int_req;
  logic        leave_act;
  logic        enter_idle;

  function automatic logic lane_hit(input logic [3:0] be,
                                    input int         lane);
    lane_hit = be[lane];
  endfunction : lane_hit

  // causes are latched in sticky flags
  lisa_flag_bank u_flags (
    .core_clk (core_clk),
    .rstn     (rstn),
    .set_vec  (set_vec),
    .ack_vec  (ack_vec),
    .cause    (cause)
  );

  // ones written to the cause byte acknowledge
  always_comb begin
    ack_vec = 8'h00;
    if (reg_wr && lane_hit(reg_be, `LISA_CAUSE_BYTE)) begin
      ack_vec = reg_wdata[`LISA_CAUSE_MSB:`LISA_CAUSE_LSB];
    end
  end

  assign leave_act  = st.ces[1] & ~ces_in[1];
  assign enter_idle = (st.ces != `LISA_CES_IDLE) &&
                      (ces_in == `LISA_CES_IDLE);

  always_comb begin
    set_vec = 8'h00;
    set_vec[`LISA_C_CMD] = cmd_done_evt |
                           (early_variant & tno_enable & tx_fail_evt);
    // frame or header depending on mode
    set_vec[`LISA_C_FRAME] = header_mode ? header_done_evt
                                         : frame_done_evt;
    // inactive or idle entry by mode
    set_vec[`LISA_C_INACT] = idle_event_mode ? enter_idle : leave_act;
    set_vec[`LISA_C_STALL] = (st.res == `LISA_RES_READY) &&
                             (res_in != `LISA_RES_READY);
    set_vec[`LISA_C_MGMT] = mgmt_done_evt & mgmt_irq_enable;
    // software request through the control byte
    set_vec[`LISA_C_SOFT] = reg_wr &
                            lane_hit(reg_be, `LISA_ICTL_BYTE) &
                            reg_wdata[`LISA_SREQ_BIT];
    set_vec[`LISA_C_RSV] = 1'b0;
    // pause event, not in earliest variant
    set_vec[`LISA_C_PAUSE] = pause_evt & ~early_variant;
  end

  // gates for command, frame, inactive, stall and pause, absent in earliest variant
  always_comb begin
    gate_vec = 8'h00;
    if (!early_variant) begin
      gate_vec[`LISA_C_CMD]   = st.gate[5];
      gate_vec[`LISA_C_FRAME] = st.gate[4];
      gate_vec[`LISA_C_INACT] = st.gate[3];
      gate_vec[`LISA_C_STALL] = st.gate[2];
      gate_vec[`LISA_C_PAUSE] = st.gate[0];
    end
  end

  assign int_req = ~st.blk & (|(cause & ~gate_vec));

  always_comb begin
    next_st = st;
    if (reg_wr && lane_hit(reg_be, `LISA_ICTL_BYTE)) begin
      next_st.blk  = reg_wdata[`LISA_BLK_BIT];
      next_st.gate = reg_wdata[`LISA_GATE_MSB:`LISA_GATE_LSB];
    end
    // state fields follow the engines one cycle late
    next_st.ces = ces_in;
    next_st.res = res_in;
    // line holds until no request remains
    // level only, no new edge per event
    unique case (st.line)
      LISA_LINE_IDLE: begin
        if (int_req) begin
          next_st.line = LISA_LINE_ON;
        end
      end
      LISA_LINE_ON: begin
        if (!int_req) begin
          next_st.line = LISA_LINE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st.gate <= `LISA_GATE_RST;
      st.blk  <= `LISA_BLK_RST;
      st.ces  <= `LISA_CES_RST;
      st.res  <= `LISA_RES_RST;
      st.line <= LISA_LINE_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // dword read view, byte lanes independent
  always_comb begin
    reg_rdata = 32'h0000_0000;
    reg_rdata[`LISA_CAUSE_MSB:`LISA_CAUSE_LSB] = cause;
    reg_rdata[`LISA_CES_MSB:`LISA_CES_LSB] = st.ces;
    reg_rdata[`LISA_RES_MSB:`LISA_RES_LSB] = st.res;
    reg_rdata[`LISA_BLK_BIT] = st.blk;
    if (!early_variant) begin
      reg_rdata[`LISA_GATE_MSB:`LISA_GATE_LSB] = st.gate;
    end
  end

  assign intr_pin_out  = 1'b0;
  assign intr_pin_oe_n = (st.line != LISA_LINE_ON);

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  logic wr_cause;
  logic wr_ictl;
  assign wr_cause = reg_wr && reg_be[`LISA_CAUSE_BYTE];
  assign wr_ictl  = reg_wr && reg_be[`LISA_ICTL_BYTE];

  a_ack_clears_flag: assert property (
    wr_cause && reg_wdata[15] && cause[`LISA_C_CMD] &&
    !set_vec[`LISA_C_CMD] |=> !reg_rdata[15])
    else $error("acknowledged command flag stayed set");

  a_zero_keeps_flag: assert property (
    wr_cause && !reg_wdata[14] && reg_rdata[14] |=> reg_rdata[14])
    else $error("zero acknowledge bit cleared frame flag");

  a_set_beats_ack: assert property (
    (set_vec & ack_vec) != 8'h00 |=>
    (cause & $past(set_vec)) == $past(set_vec))
    else $error("event lost under simultaneous acknowledge");

  a_line_follows_req: assert property (
    int_req |=> !intr_pin_oe_n)
    else $error("pending cause did not assert the line");

  a_line_holds_req: assert property (
    !intr_pin_oe_n && int_req |=> !intr_pin_oe_n)
    else $error("line dropped with a cause still pending");

  a_block_wins: assert property (
    st.blk |=> intr_pin_oe_n)
    else $error("line asserted while block bit set");

  a_gate_masks_cmd: assert property (
    !early_variant && st.gate[5] &&
    (cause == 8'h80) |=> intr_pin_oe_n)
    else $error("gated command cause reached the line");

  a_stall_on_leave: assert property (
    res_in == `LISA_RES_READY ##1 res_in != `LISA_RES_READY
    |=> reg_rdata[12])
    else $error("leaving ready did not set stall flag");

  a_mgmt_gated: assert property (
    mgmt_done_evt && !mgmt_irq_enable && !reg_rdata[11] |=>
    !reg_rdata[11])
    else $error("disabled management cycle raised its flag");

  a_soft_request: assert property (
    wr_ictl && reg_wdata[`LISA_SREQ_BIT] |=> reg_rdata[10])
    else $error("software request did not set its flag");

  a_states_lag: assert property (
    reg_rdata[7:6] == $past(ces_in, `LISA_STATE_LAG))
    else $error("command state field wrong");

  a_recv_state: assert property (
    reg_rdata[5:2] == $past(res_in, `LISA_STATE_LAG))
    else $error("receive state field wrong");

  a_reserved_zero: assert property (
    reg_rdata[9] == 1'b0 && reg_rdata[1:0] == 2'h0 &&
    reg_rdata[`LISA_SREQ_BIT] == 1'b0)
    else $error("reserved bit read as one");

  a_pause_early: assert property (
    early_variant && pause_evt && !reg_rdata[8] |=> !reg_rdata[8])
    else $error("pause flag set in earliest variant");

  a_idle_mode: assert property (
    idle_event_mode && ces_in == 2'h1 && st.ces[1] &&
    !reg_rdata[13] |=> !reg_rdata[13])
    else $error("idle mode flagged a suspend");

  c_line_cycle: cover property (
    intr_pin_oe_n ##1 !intr_pin_oe_n [*2] ##1 intr_pin_oe_n);

  c_partial_ack: cover property (
    reg_rdata[15] && reg_rdata[14] ##1 wr_cause ##1
    reg_rdata[15] && !reg_rdata[14]);

  c_set_and_ack: cover property ((set_vec & ack_vec) != 8'h00);

  c_block_pending: cover property (st.blk && |cause);

endmodule : lisa_status_ack
`default_nettype wire

// [lisa_host_pin.sv]
// host side model of the shared pci interrupt line
`timescale 1ns/10ps
`default_nettype none

module lisa_host_pin (
  input  wire logic pin_out,   // device drive value
  input  wire logic pin_oe_n,  // device enable, low while driving
  output logic      pin_level  // resolved line level
);
  assign pin_level = pin_oe_n ? 1'b1 : pin_out;
endmodule : lisa_host_pin
`default_nettype wire

// [tb.sv]
// testbench of the lan interrupt status and acknowledge block
`timescale 1ns/10ps
`default_nettype none

module tb;
  import lisa_pkg::*;
  logic        core_clk;
  logic        rstn;
  logic        reg_wr;
  logic [3:0]  reg_be;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [5:0]  evt;
  logic        tno_en;
  logic        early;
  logic        hdr_mode;
  logic        idle_mode;
  logic        mgmt_en;
  logic [1:0]  ces;
  logic [3:0]  res;
  logic        pin_out;
  logic        pin_oe_n;
  logic        pin_lvl;
  int          n_fail;
  int          comparisons;
  int          src[4] = '{0, 2, 4, 5};
  logic [7:0]  msk[4] = '{8'h80, 8'h40, 8'h08, 8'h01};
  logic [3:0]  rsc[4] = '{4'h0, 4'h1, 4'h2, 4'h4};

  lisa_status_ack i_lisa_status_ack (
    .core_clk        (core_clk),
    .rstn            (rstn),
    .reg_wr          (reg_wr),
    .reg_be          (reg_be),
    .reg_wdata       (reg_wdata),
    .reg_rdata       (reg_rdata),
    .cmd_done_evt    (evt[0]),
    .tx_fail_evt     (evt[1]),
    .tno_enable      (tno_en),
    .early_variant   (early),
    .frame_done_evt  (evt[2]),
    .header_done_evt (evt[3]),
    .header_mode     (hdr_mode),
    .idle_event_mode (idle_mode),
    .ces_in          (ces),
    .res_in          (res),
    .mgmt_done_evt   (evt[4]),
    .mgmt_irq_enable (mgmt_en),
    .pause_evt       (evt[5]),
    .intr_pin_in     (pin_lvl),
    .intr_pin_out    (pin_out),
    .intr_pin_oe_n   (pin_oe_n)
  );

  lisa_host_pin i_lisa_host_pin (
    .pin_out   (pin_out),
    .pin_oe_n  (pin_oe_n),
    .pin_level (pin_lvl)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task test_done;
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task tick;
    @(posedge core_clk);
    #10;
  endtask : tick

  task fire(input int k);
    tick();
    evt[k] = 1'b1;
    tick();
    evt = 6'h00;
  endtask : fire

  task wr(input logic [3:0] be, input logic [31:0] d);
    tick();
    reg_wr = 1'b1;
    reg_be = be;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
    reg_be = 4'h0;
  endtask : wr

  task pin(input logic e);
    tick();
    chk("pin", 32'(e), 32'(pin_lvl));
  endtask : pin

  task cause(input logic [7:0] e);
    chk("cause", 32'(e), 32'(reg_rdata[15:8]));
  endtask : cause

  task st(input logic [1:0] c, input logic [3:0] r);
    tick();
    ces = c;
    res = r;
    tick();
  endtask : st

  initial begin
    repeat (2000) @(posedge core_clk);
    n_fail++;
    test_done();
  end

  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_be = 4'h0;
    reg_wdata = 32'h0;
    evt = 6'h00;
    tno_en = 1'b0;
    early = 1'b0;
    hdr_mode = 1'b0;
    idle_mode = 1'b0;
    mgmt_en = 1'b1;
    ces = 2'h0;
    res = 4'h0;
    repeat (16) @(posedge core_clk);
    #10;
    rstn = 1'b1;
    chk("rdata", 32'h0, reg_rdata);
    chk("pin", 32'h1, 32'(pin_lvl));
    for (int i = 0; i < 4; i++) begin
      fire(src[i]);
      cause(msk[i]);
      pin(1'b0);
      wr(4'h2, {16'h0, msk[i], 8'h0});
      cause(8'h00);
      pin(1'b1);
    end
    wr(4'h8, 32'h0200_0000);
    cause(8'h04);
    pin(1'b0);
    wr(4'h2, 32'h0000_0400);
    fire(0);
    fire(2);
    wr(4'h2, 32'h0000_7f00);
    cause(8'h80);
    pin(1'b0);
    wr(4'h3, 32'h0000_00ff);
    cause(8'h80);
    chk("status", 32'h0, 32'(reg_rdata[7:0]));
    fire(2);
    pin(1'b0);
    wr(4'h2, 32'h0000_c000);
    pin(1'b1);
    // event and acknowledge meet at one edge
    tick();
    evt[0] = 1'b1;
    reg_wr = 1'b1;
    reg_be = 4'h2;
    reg_wdata = 32'h0000_8000;
    tick();
    evt = 6'h00;
    reg_wr = 1'b0;
    cause(8'h80);
    wr(4'h2, 32'h0000_8000);
    wr(4'h8, 32'h0300_0000);
    chk("block", 32'h0100_0400, reg_rdata & 32'hffff_ff00);
    fire(0);
    pin(1'b1);
    wr(4'h8, 32'h0);
    pin(1'b0);
    wr(4'h2, 32'h0000_8400);
    wr(4'h8, 32'h8000_0000);
    fire(0);
    pin(1'b1);
    fire(2);
    pin(1'b0);
    wr(4'h2, 32'h0000_4000);
    pin(1'b1);
    wr(4'h2, 32'h0000_8000);
    wr(4'h8, 32'h7c00_0000);
    chk("gates", 32'h7c00_0000, reg_rdata & 32'hfc00_0000);
    fire(2);
    fire(5);
    pin(1'b1);
    wr(4'h2, 32'h0000_4100);
    wr(4'h8, 32'h0);
    for (int i = 0; i < 4; i++) begin
      st(2'(i), rsc[i]);
      chk("states", 32'({2'(i), rsc[i], 2'h0}), reg_rdata & 32'hff);
    end
    st(2'h3, 4'h2);
    cause(8'h10);
    st(2'h2, 4'h2);
    st(2'h1, 4'h2);
    cause(8'h30);
    wr(4'h2, 32'h0000_ff00);
    chk("word", 32'h0000_0048, reg_rdata);
    idle_mode = 1'b1;
    st(2'h2, 4'h2);
    st(2'h1, 4'h2);
    cause(8'h00);
    st(2'h0, 4'h2);
    cause(8'h20);
    wr(4'h2, 32'h0000_2000);
    mgmt_en = 1'b0;
    fire(4);
    cause(8'h00);
    hdr_mode = 1'b1;
    fire(2);
    cause(8'h00);
    fire(3);
    cause(8'h40);
    wr(4'h2, 32'h0000_4000);
    tno_en = 1'b1;
    fire(1);
    cause(8'h00);
    early = 1'b1;
    fire(5);
    cause(8'h00);
    fire(1);
    cause(8'h80);
    wr(4'h8, 32'hfc00_0000);
    chk("gates", 32'h0, reg_rdata & 32'hfc00_0000);
    test_done();
  end
endmodule : tb
`default_nettype wire
